// *** rtl/rfp_rail_fault_protection.sv ***
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Over-current trips after 40 us persistence
// - Over-current ignored during voltage change, soft-start
// - Over-current re-armed 46 us after end alert
// - Over-voltage at target+150mV, or 1V+350mV at or below 1V
// - Over-voltage forces high gates low, low gates high
// - Over-voltage trips after 0.5 us persistence
// - Over-voltage masked, re-armed 46 us after alert
// - Below -0.07V after trip, low gates off
// - Above 0V, trip latch turns low gates on
// - Negative protection only after over-voltage trip
// - Over-current threshold chosen from setting pin one code
module rfp_rail_fault_protection #(
  parameter int unsigned PHASES     = 2,
  parameter int unsigned OC_QUAL    = rfp_pkg::OC_QUAL_CYC,
  parameter int unsigned REARM      = rfp_pkg::REARM_CYC
) (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     dynamic_voltage_change,
  input  wire logic                     soft_start,
  input  wire logic                     end_alert,
  input  wire logic [rfp_pkg::SET_W-1:0] rail_setting_pin_one,
  input  wire logic [rfp_pkg::CUR_W-1:0] max_rail_current,
  input  wire logic [rfp_pkg::CUR_W-1:0] rail_current,
  input  wire logic [rfp_pkg::MV_W-1:0]  target_voltage_code,
  input  wire logic [rfp_pkg::MV_W-1:0]  rail_sense_input,
  input  wire logic                     sense_below_neg,
  input  wire logic                     sense_above_zero,
  input  wire logic [PHASES-1:0]        pwm_high,
  input  wire logic [PHASES-1:0]        pwm_low,
  output logic [PHASES-1:0]             high_side_gate,
  output logic [PHASES-1:0]             low_side_gate,
  output logic                          overcurrent_trip,
  output logic                          overvoltage_trip,
  output logic                          negative_voltage_trip
);

  // ==========================================================================
  // Input synchronisers: the first stage feeds only the second.
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] next_sync1;
  logic [4:0] next_sync2;
  logic       dvc_s;
  logic       ss_s;
  logic       alert_s;
  logic       neg_s;
  logic       zero_s;
  logic       alert_d;
  logic       next_alert_d;

  always_comb begin
    next_sync1 = {dynamic_voltage_change, soft_start, end_alert,
                  sense_below_neg, sense_above_zero};
    next_sync2 = sync1;
    next_alert_d = alert_s;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1   <= '0;
      sync2   <= '0;
      alert_d <= 1'b0;
    end else begin
      sync1   <= next_sync1;
      sync2   <= next_sync2;
      alert_d <= next_alert_d;
    end
  end

  assign {dvc_s, ss_s, alert_s, neg_s, zero_s} = sync2;

  // ==========================================================================
  // Mask and re-arm. Detection stays masked while a change or soft-start
  // runs, and for the hold-off counted from the rising edge of the alert.
  localparam int unsigned RW = $clog2(REARM + 1);
  logic          armed;
  logic          next_armed;
  logic [RW-1:0] rearm_cnt;
  logic [RW-1:0] next_rearm_cnt;
  logic          alert_rise;

  assign alert_rise = alert_s & ~alert_d;

  always_comb begin
    next_armed     = armed;
    next_rearm_cnt = rearm_cnt;
    if (dvc_s || ss_s) begin
      next_armed     = 1'b0;
      next_rearm_cnt = '0;
    end else if (alert_rise) begin
      next_rearm_cnt = RW'(REARM);
    end else if (rearm_cnt != '0) begin
      next_rearm_cnt = rearm_cnt - RW'(1);
      if (rearm_cnt == RW'(1)) begin
        next_armed = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      armed     <= 1'b0;
      rearm_cnt <= '0;
    end else begin
      armed     <= next_armed;
      rearm_cnt <= next_rearm_cnt;
    end
  end

  // ==========================================================================
  // Threshold comparison.
  logic [rfp_pkg::CUR_W+7:0] oc_limit_x100;
  logic [rfp_pkg::CUR_W+7:0] cur_x100;
  logic [rfp_pkg::MV_W:0]    ov_limit;
  logic                      live;
  logic                      oc_cond;
  logic                      ov_cond;

  // Masks act on the synchronised levels at once: waiting for armed to fall
  // would leave one cycle in which a running count could still complete.
  always_comb begin
    live = armed && !dvc_s && !ss_s;
    oc_limit_x100 = max_rail_current *
      rfp_pkg::OC_PCT_TABLE[rail_setting_pin_one];
    cur_x100 = rail_current * 8'h64;
    if (target_voltage_code > rfp_pkg::ONE_VOLT_MV) begin
      ov_limit = {1'b0, target_voltage_code} +
                 {1'b0, rfp_pkg::OV_MARGIN_HI_MV};
    end else begin
      ov_limit = {1'b0, rfp_pkg::ONE_VOLT_MV} +
                 {1'b0, rfp_pkg::OV_MARGIN_LO_MV};
    end
    oc_cond = live && (cur_x100 > oc_limit_x100);
    ov_cond = live && ({1'b0, rail_sense_input} > ov_limit);
  end

  // ==========================================================================
  // Qualification timers and latches.
  localparam int unsigned OW = $clog2(OC_QUAL + 1);
  localparam int unsigned VW = $clog2(rfp_pkg::OV_QUAL_CYC + 1);
  logic [OW-1:0] oc_cnt;
  logic [OW-1:0] next_oc_cnt;
  logic [VW-1:0] ov_cnt;
  logic [VW-1:0] next_ov_cnt;
  logic          next_oc_trip;
  rfp_pkg::rfp_ov_state_t ov_state;
  rfp_pkg::rfp_ov_state_t next_ov_state;

  always_comb begin
    next_oc_cnt  = '0;
    next_oc_trip = overcurrent_trip;
    if (oc_cond && !overcurrent_trip) begin
      next_oc_cnt = oc_cnt + OW'(1);
      if (oc_cnt == OW'(OC_QUAL - 1)) begin
        next_oc_trip = 1'b1;
      end
    end
  end

  always_comb begin
    next_ov_cnt   = '0;
    next_ov_state = ov_state;
    unique case (ov_state)
      rfp_pkg::RFP_RUN: begin
        if (ov_cond) begin
          next_ov_cnt = ov_cnt + VW'(1);
          if (ov_cnt == VW'(rfp_pkg::OV_QUAL_CYC - 1)) begin
            next_ov_state = rfp_pkg::RFP_OV_CLAMP;
          end
        end
      end
      rfp_pkg::RFP_OV_CLAMP: begin
        if (neg_s) begin
          next_ov_state = rfp_pkg::RFP_NEG_PROT;
        end
      end
      rfp_pkg::RFP_NEG_PROT: begin
        if (zero_s) begin
          next_ov_state = rfp_pkg::RFP_OV_CLAMP;
        end
      end
      default: next_ov_state = rfp_pkg::RFP_RUN;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oc_cnt           <= '0;
      ov_cnt           <= '0;
      overcurrent_trip <= 1'b0;
      ov_state         <= rfp_pkg::RFP_RUN;
    end else begin
      oc_cnt           <= next_oc_cnt;
      ov_cnt           <= next_ov_cnt;
      overcurrent_trip <= next_oc_trip;
      ov_state         <= next_ov_state;
    end
  end

  // ==========================================================================
  // Gate drive. Outputs are registered from the next state, so forced states
  // change on the same clock as the state; pwm levels pass one clock late.
  logic [PHASES-1:0] next_high;
  logic [PHASES-1:0] next_low;
  logic              next_ov_trip;
  logic              next_nv_trip;

  always_comb begin
    next_ov_trip = (next_ov_state != rfp_pkg::RFP_RUN);
    next_nv_trip = (next_ov_state == rfp_pkg::RFP_NEG_PROT);
    next_high    = pwm_high;
    next_low     = pwm_low;
    if (next_nv_trip) begin
      next_high = '0;
      next_low  = '0;
    end else if (next_ov_trip) begin
      next_high = '0;
      next_low  = '1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      high_side_gate        <= '0;
      low_side_gate         <= '0;
      overvoltage_trip      <= 1'b0;
      negative_voltage_trip <= 1'b0;
    end else begin
      high_side_gate        <= next_high;
      low_side_gate         <= next_low;
      overvoltage_trip      <= next_ov_trip;
      negative_voltage_trip <= next_nv_trip;
    end
  end

  // ==========================================================================
  // Checks.
  chk_ov_forces_gates: assert property (
    @(posedge mclk) disable iff (rst)
    overvoltage_trip && !negative_voltage_trip |->
      high_side_gate == '0 && low_side_gate == '1)
    else $error("Gates not forced during over-voltage clamp.");

  chk_nv_gates_off: assert property (
    @(posedge mclk) disable iff (rst)
    negative_voltage_trip |-> high_side_gate == '0 && low_side_gate == '0)
    else $error("Gates not off during negative protection.");

  chk_nv_needs_ov: assert property (
    @(posedge mclk) disable iff (rst)
    negative_voltage_trip |-> overvoltage_trip)
    else $error("Negative protection without over-voltage trip.");

  chk_ov_sticky: assert property (
    @(posedge mclk) disable iff (rst)
    overvoltage_trip |=> overvoltage_trip)
    else $error("Over-voltage trip dropped.");

  chk_oc_sticky: assert property (
    @(posedge mclk) disable iff (rst)
    overcurrent_trip |=> overcurrent_trip)
    else $error("Over-current trip dropped.");

  chk_oc_masked: assert property (
    @(posedge mclk) disable iff (rst)
    (dvc_s || ss_s) && !overcurrent_trip |=> !overcurrent_trip)
    else $error("Over-current tripped while masked.");

  chk_ov_masked: assert property (
    @(posedge mclk) disable iff (rst)
    (dvc_s || ss_s) && !overvoltage_trip |=> !overvoltage_trip)
    else $error("Over-voltage tripped while masked.");

  chk_oc_qual_time: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(overcurrent_trip) |-> $past(oc_cnt) == OW'(OC_QUAL - 1))
    else $error("Over-current tripped before qualification.");

  chk_ov_not_early: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(overvoltage_trip) |->
      $past(ov_cnt) == VW'(rfp_pkg::OV_QUAL_CYC - 1))
    else $error("Over-voltage tripped before qualification.");

  // Thirteen cycles of the condition make up the over-voltage filter.
  sequence s_ov_hold;
    ov_cond [*8] ##1 ov_cond [*5];
  endsequence

  chk_ov_qual_time: assert property (
    @(posedge mclk) disable iff (rst)
    ($rose(ov_cond) && ov_state == rfp_pkg::RFP_RUN) ##0 s_ov_hold
      |=> overvoltage_trip)
    else $error("Over-voltage not latched after qualification.");

  chk_rearm_time: assert property (
    @(posedge mclk) disable iff (rst)
    alert_rise && !dvc_s && !ss_s |=> rearm_cnt == RW'(REARM))
    else $error("Re-arm hold-off not loaded on alert.");

  chk_nv_exit: assert property (
    @(posedge mclk) disable iff (rst)
    ov_state == rfp_pkg::RFP_NEG_PROT && zero_s |=> low_side_gate == '1)
    else $error("Low gates not restored above zero.");

endmodule
`default_nettype wire

// *** shared/rfp_pkg.sv ***
`default_nettype none
package rfp_pkg;
  // ==========================================================================
  // Clock and timing.
  localparam int unsigned CLK_MHZ       = 25;
  localparam int unsigned OC_QUAL_NS    = 40000;
  localparam int unsigned REARM_NS      = 46000;
  localparam int unsigned OV_QUAL_NS    = 500;
  localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
  // Least times round up to whole cycles.
  localparam int unsigned OC_QUAL_CYC =
    (OC_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REARM_CYC =
    (REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OV_QUAL_CYC =
    (OV_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Voltage thresholds in millivolts.
  localparam logic [11:0] OV_MARGIN_HI_MV = 12'h096;
  localparam logic [11:0] OV_MARGIN_LO_MV = 12'h15E;
  localparam logic [11:0] ONE_VOLT_MV     = 12'h3E8;

  localparam int unsigned SET_W  = 3;
  localparam int unsigned CUR_W  = 10;
  localparam int unsigned MV_W   = 12;

  // Over-current threshold as a percentage of the maximum rail current.
  localparam logic [7:0] OC_PCT_TABLE [8] = '{
    8'h6E, 8'h78, 8'h82, 8'h8C, 8'h96, 8'hA0, 8'hAA, 8'hB4};

  typedef enum logic [1:0] {
    RFP_RUN,
    RFP_OV_CLAMP,
    RFP_NEG_PROT
  } rfp_ov_state_t;
endpackage
`default_nettype wire

// *** test/rfp_sense_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Analog front end that faces the block: the sense converter and comparators.
module rfp_sense_model (
  input  wire logic signed [15:0]        sense_mv,
  output logic [rfp_pkg::MV_W-1:0]       rail_sense_input,
  output logic                           sense_below_neg,
  output logic                           sense_above_zero
);
  // The converter cannot show a negative level, so it clips at zero.
  always_comb begin
    rail_sense_input = (sense_mv < 0) ? '0 : sense_mv[rfp_pkg::MV_W-1:0];
    sense_below_neg  = (sense_mv < -70);
    sense_above_zero = (sense_mv > 0);
  end
endmodule
`default_nettype wire

// *** test/test_rail_fault_protection.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_rail_fault_protection;
  logic               mclk;
  logic               rst;
  logic               dvc;
  logic               ss;
  logic               ea;
  logic [2:0]         setp;
  logic [9:0]         maxc;
  logic [9:0]         cur;
  logic [11:0]        tgt;
  logic signed [15:0] smv;
  logic [11:0]        rsi;
  logic               below;
  logic               above;
  logic [1:0]         pwm_h;
  logic [1:0]         pwm_l;
  logic [1:0]         hg;
  logic [1:0]         lg;
  logic               oct;
  logic               ovt;
  logic               nvt;
  int                 err_total;
  int                 check_count;
  int                 cycles;

  rfp_sense_model afe (.sense_mv(smv), .rail_sense_input(rsi),
    .sense_below_neg(below), .sense_above_zero(above));
  rfp_rail_fault_protection #(.PHASES(2), .OC_QUAL(20), .REARM(30)) uut (
    .mclk(mclk), .rst(rst), .dynamic_voltage_change(dvc), .soft_start(ss),
    .end_alert(ea), .rail_setting_pin_one(setp), .max_rail_current(maxc),
    .rail_current(cur), .target_voltage_code(tgt), .rail_sense_input(rsi),
    .sense_below_neg(below), .sense_above_zero(above), .pwm_high(pwm_h),
    .pwm_low(pwm_l), .high_side_gate(hg), .low_side_gate(lg),
    .overcurrent_trip(oct), .overvoltage_trip(ovt),
    .negative_voltage_trip(nvt));

  // ==========================================================================
  // Clock, timeout and shared tasks.
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic do_reset();
    rst = 1;
    cyc(12);
    rst = 0;
  endtask

  // Only a fresh alert edge with both masks low starts the hold-off.
  task automatic arm();
    ea = 0;
    cyc(2);
    ea = 1;
    cyc(40);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_pass();
    do_reset();
    check(oct, 0);
    check(ovt, 0);
    check(nvt, 0);
    check(hg, 0);
    check(lg, 0);
    cyc(2);
    check(hg, pwm_h);
    check(lg, pwm_l);
    pwm_h = 2'b10;
    pwm_l = 2'b01;
    cyc(2);
    check(hg, 2'b10);
    check(lg, 2'b01);
    pwm_h = 2'b11;
    pwm_l = 2'b00;
    cyc(2);
    $display("test pass-through done");
  endtask

  task automatic t_mask();
    do_reset();
    maxc = 100;
    cur = 200;
    smv = 1400;
    cyc(60);
    check(ovt, 0);
    check(oct, 0);
    dvc = 1;
    arm();
    check(ovt, 0);
    check(oct, 0);
    dvc = 0;
    ss = 1;
    arm();
    check(oct, 0);
    check(ovt, 0);
    ss = 0;
    ea = 0;
    cyc(2);
    ea = 1;
    cyc(20);
    check(oct, 0);
    check(ovt, 0);
    cyc(50);
    check(oct, 1);
    check(ovt, 1);
    cur = 0;
    smv = 0;
    $display("test masking done");
  endtask

  task automatic t_oc();
    logic [9:0] pct;
    for (int c = 0; c < 8; c++) begin
      do_reset();
      setp = c[2:0];
      maxc = 100;
      pct = 10'(110 + 10 * c);
      cur = pct;
      arm();
      cyc(40);
      check(oct, 0);
      cur = pct + 1;
      cyc(10);
      cur = pct;
      cyc(30);
      check(oct, 0);
      cur = pct + 1;
      cyc(30);
      check(oct, 1);
      cur = 0;
      cyc(5);
      check(oct, 1);
    end
    $display("test over-current done");
  endtask

  task automatic t_ov();
    logic signed [15:0] lim;
    for (int i = 0; i < 2; i++) begin
      do_reset();
      tgt = (i == 0) ? 12'h44C : 12'h384;
      lim = (i == 0) ? 16'sd1250 : 16'sd1350;
      arm();
      smv = lim;
      cyc(30);
      check(ovt, 0);
      smv = lim + 1;
      cyc(8);
      smv = lim;
      cyc(10);
      check(ovt, 0);
      smv = lim + 1;
      cyc(20);
      check(ovt, 1);
      check(hg, 0);
      check(lg, 2'b11);
      smv = 0;
    end
    $display("test over-voltage done");
  endtask

  task automatic t_nv();
    do_reset();
    tgt = 12'h44C;
    smv = -100;
    arm();
    check(nvt, 0);
    smv = 1300;
    cyc(20);
    check(ovt, 1);
    smv = -100;
    cyc(6);
    check(nvt, 1);
    check(lg, 0);
    check(hg, 0);
    smv = 50;
    cyc(6);
    check(nvt, 0);
    check(lg, 2'b11);
    check(ovt, 1);
    $display("test negative protection done");
  endtask

  initial begin
    {err_total, check_count, cycles} = 0;
    {dvc, ss, ea, setp, cur, smv} = 0;
    rst = 1;
    maxc = 100;
    tgt = 12'h44C;
    pwm_h = 2'b11;
    pwm_l = 2'b00;
    cyc(1);
    t_pass();
    t_mask();
    t_oc();
    t_ov();
    t_nv();
    print_verdict();
  end
endmodule
`default_nettype wire
